// ### design/supply_status_pkg.sv
package supply_status_pkg;
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h20;
	localparam logic [7:0] STATUS_CMD = 8'h55;
	localparam logic [7:0] CTRL_WR_MASK = 8'hfc;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int unsigned ST_OVERRIDE_BIT = 7;
	localparam int unsigned ST_FAIL_BIT = 6;
	localparam int unsigned ST_OT_BIT = 5;
	localparam int unsigned ST_PREC_BIT = 4;
	localparam int unsigned ST_HOLD_BIT = 3;
	localparam int unsigned ST_TURN_BIT = 2;
	localparam logic [1:0] REPEAT_NEEDED = 2'h3;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] TX_LAST_BIT = 4'h7;
	localparam logic [1:0] IDX_CMD = 2'h0;
	localparam logic [1:0] IDX_DATA = 2'h1;
	localparam logic [1:0] IDX_SUM = 2'h2;
	localparam logic [1:0] IDX_DONE = 2'h3;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned RETRY_TIME_MS = 1000;
	localparam int unsigned RETRY_CYCLES = RETRY_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned SYNC_BITS = 4;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_RX = 3'b010,
		ST_ACK = 3'b011,
		ST_TX = 3'b100,
		ST_MACK = 3'b101
	} link_state_t;
endpackage : supply_status_pkg

// ### design/pin_sync2.sv
`timescale 1ns/1ns
module pin_sync2 #(
	parameter int unsigned WIDTH = 4
) (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// The first stage feeds only the second; metastability settles between them.
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic meta_r;
		logic stable_r;
		always_ff @(posedge clk_sys_in or negedge rstn_in) begin
			if (!rstn_in) begin
				meta_r <= 1'b1;
				stable_r <= 1'b1;
			end else begin
				meta_r <= async_in[i];
				stable_r <= meta_r;
			end
		end
		assign sync_out[i] = stable_r;
	end
endmodule : pin_sync2

// ### design/supply_status_override_ctrl.sv
`timescale 1ns/1ns
module supply_status_override_ctrl #(
	parameter logic [6:0] DEV_ADDR = supply_status_pkg::DEV_ADDR_DEFAULT,
	parameter int unsigned RETRY_CYCLES = supply_status_pkg::RETRY_CYCLES
) (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic turn_on_n_in,
	input wire logic hold_off_n_in,
	input wire logic fault_in,
	input wire logic overtemp_fault_in,
	input wire logic nonrecov_fault_in,
	output logic outputs_on_out,
	output logic event_msg_out,
	output logic override_active_out
);
	import supply_status_pkg::*;

	logic [3:0] sync_w;
	logic scl_s;
	logic sda_s;
	logic pin_turn_on_mirror;
	logic pin_hold_off_mirror;
	logic scl_p_r;
	logic sda_p_r;
	link_state_t st_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] tx_sh_r;
	logic [7:0] tx_byte_r;
	logic [1:0] tx_idx_r;
	logic [7:0] snap_r;
	logic [7:0] data_r;
	logic [1:0] byte_idx_r;
	logic rw_r;
	logic sda_oe_r;
	logic frame_good_r;
	logic [7:0] ctrl_r;
	logic [1:0] rep_cnt_r;
	logic [7:0] last_data_r;
	logic shut_r;
	logic [31:0] retry_cnt_r;
	logic fault_p_r;
	logic ot_p_r;
	logic nonrec_p_r;
	logic outputs_on_r;
	logic event_msg_r;

	pin_sync2 #(
		.WIDTH(SYNC_BITS)
	) u_sync (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.async_in({scl_in, sda_in, turn_on_n_in, hold_off_n_in}),
		.sync_out(sync_w)
	);
	assign scl_s = sync_w[3];
	assign sda_s = sync_w[2];
	assign pin_turn_on_mirror = sync_w[1];
	assign pin_hold_off_mirror = sync_w[0];

	// Link condition decode on the synchronised pins.
	logic start_w;
	logic stop_w;
	logic scl_rise_w;
	logic scl_fall_w;
	logic byte_done_w;
	logic addr_hit_w;
	assign start_w = scl_s && scl_p_r && sda_p_r && !sda_s;
	assign stop_w = scl_s && scl_p_r && !sda_p_r && sda_s;
	assign scl_rise_w = scl_s && !scl_p_r;
	assign scl_fall_w = !scl_s && scl_p_r;
	assign byte_done_w = scl_fall_w && (bit_cnt_r == BITS_PER_BYTE)
		&& (st_r == ST_ADDR || st_r == ST_RX);
	assign addr_hit_w = (shift_r[7:1] == DEV_ADDR);
	// Status byte as read back; the low two bits are live pin mirrors.
	logic [7:0] status_w;
	assign status_w = {ctrl_r[7:2], pin_hold_off_mirror, pin_turn_on_mirror};
	// Write frame checking and the three-fold arming sequence.
	logic sum_ok_w;
	logic wr_commit_w;
	logic wr_bad_w;
	logic same_data_w;
	logic [1:0] rep_nxt;
	logic arm_w;
	logic [7:0] written_w;
	logic [7:0] clear_mask_w;
	logic [7:0] ctrl_nxt;
	assign sum_ok_w = (8'(STATUS_CMD + data_r + shift_r) == 8'h00);
	assign wr_commit_w = byte_done_w && st_r == ST_RX && byte_idx_r == IDX_SUM && sum_ok_w;
	assign wr_bad_w = byte_done_w && st_r == ST_RX && byte_idx_r == IDX_SUM && !sum_ok_w;
	assign same_data_w = (rep_cnt_r != 2'h0) && (data_r == last_data_r);
	assign rep_nxt = !same_data_w ? 2'h1 :
		(rep_cnt_r == REPEAT_NEEDED) ? REPEAT_NEEDED : rep_cnt_r + 2'h1;
	assign arm_w = data_r[ST_OVERRIDE_BIT]
		&& (rep_nxt == REPEAT_NEEDED || ctrl_r[ST_OVERRIDE_BIT]);
	assign written_w = {arm_w, data_r[6:0]} & CTRL_WR_MASK;
	// A fault in the same cycle as a write wins, so the flag never hides a fresh fault.
	assign clear_mask_w = ~(({7'h00, fault_in} << ST_FAIL_BIT)
		| ({7'h00, overtemp_fault_in} << ST_OT_BIT));
	assign ctrl_nxt = (wr_commit_w ? written_w : ctrl_r) & clear_mask_w;
	// Response bytes: command echo, status snapshot, zero checksum.
	logic [7:0] tx_next_w;
	logic [1:0] tx_idx_nxt;
	assign tx_idx_nxt = (tx_idx_r == IDX_DONE) ? IDX_DONE : tx_idx_r + 2'h1;
	assign tx_next_w = (tx_idx_nxt == IDX_DATA) ? snap_r :
		(tx_idx_nxt == IDX_SUM) ? 8'(8'h00 - STATUS_CMD - snap_r) : 8'h00;

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_r <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_sh_r <= 8'h00;
			tx_byte_r <= 8'h00;
			tx_idx_r <= IDX_CMD;
			snap_r <= 8'h00;
			data_r <= 8'h00;
			byte_idx_r <= IDX_CMD;
			rw_r <= 1'b0;
			sda_oe_r <= 1'b0;
			frame_good_r <= 1'b0;
		end else if (start_w) begin
			st_r <= ST_ADDR;
			bit_cnt_r <= 4'h0;
			sda_oe_r <= 1'b0;
			frame_good_r <= 1'b0;
		end else if (stop_w) begin
			st_r <= ST_IDLE;
			sda_oe_r <= 1'b0;
		end else begin
			case (st_r)
				ST_ADDR, ST_RX: begin
					if (scl_rise_w && bit_cnt_r != BITS_PER_BYTE) begin
						shift_r <= {shift_r[6:0], sda_s};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					if (byte_done_w && st_r == ST_ADDR) begin
						if (addr_hit_w) begin
							st_r <= ST_ACK;
							sda_oe_r <= 1'b1;
							rw_r <= shift_r[0];
							byte_idx_r <= IDX_CMD;
							tx_idx_r <= IDX_CMD;
							tx_byte_r <= STATUS_CMD;
							snap_r <= status_w;
						end else begin
							st_r <= ST_IDLE;
						end
					end else if (byte_done_w) begin
						// An unknown command is not acknowledged.
						if (byte_idx_r == IDX_CMD && shift_r != STATUS_CMD) begin
							st_r <= ST_IDLE;
						end else begin
							st_r <= ST_ACK;
							sda_oe_r <= 1'b1;
							if (byte_idx_r != IDX_DONE) begin
								byte_idx_r <= byte_idx_r + 2'h1;
							end
							if (byte_idx_r == IDX_DATA) begin
								data_r <= shift_r;
							end
							if (wr_commit_w) begin
								frame_good_r <= 1'b1;
							end
						end
					end
				end
				ST_ACK: begin
					if (scl_fall_w) begin
						bit_cnt_r <= 4'h0;
						if (rw_r) begin
							st_r <= ST_TX;
							tx_sh_r <= tx_byte_r;
							sda_oe_r <= ~tx_byte_r[7];
						end else begin
							st_r <= ST_RX;
							sda_oe_r <= 1'b0;
						end
					end
				end
				ST_TX: begin
					if (scl_fall_w) begin
						if (bit_cnt_r == TX_LAST_BIT) begin
							st_r <= ST_MACK;
							sda_oe_r <= 1'b0;
							tx_idx_r <= tx_idx_nxt;
							tx_byte_r <= tx_next_w;
						end else begin
							tx_sh_r <= {tx_sh_r[6:0], 1'b0};
							sda_oe_r <= ~tx_sh_r[6];
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise_w && sda_s) begin
						st_r <= ST_IDLE;
					end else if (scl_fall_w) begin
						st_r <= ST_TX;
						bit_cnt_r <= 4'h0;
						tx_sh_r <= tx_byte_r;
						sda_oe_r <= ~tx_byte_r[7];
					end
				end
				default: begin
					st_r <= ST_IDLE;
					sda_oe_r <= 1'b0;
				end
			endcase
		end
	end
	// Any frame that is not a good write breaks the run of identical writes.
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_r <= CTRL_RESET;
			rep_cnt_r <= 2'h0;
			last_data_r <= 8'h00;
		end else begin
			ctrl_r <= ctrl_nxt;
			if (wr_commit_w) begin
				rep_cnt_r <= rep_nxt;
				last_data_r <= data_r;
			end else if (wr_bad_w || (start_w && !frame_good_r)) begin
				rep_cnt_r <= 2'h0;
			end
		end
	end
	// Output control and the shutdown retry timer.
	logic eff_turn_n_w;
	logic eff_hold_n_w;
	logic shut_trig_w;
	logic retry_done_w;
	assign eff_turn_n_w = ctrl_r[ST_PREC_BIT] ? ctrl_r[ST_TURN_BIT] : pin_turn_on_mirror;
	assign eff_hold_n_w = ctrl_r[ST_PREC_BIT] ? ctrl_r[ST_HOLD_BIT] : pin_hold_off_mirror;
	assign shut_trig_w = nonrecov_fault_in && !ctrl_r[ST_OVERRIDE_BIT];
	assign retry_done_w = (retry_cnt_r == 32'(RETRY_CYCLES - 1));

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			shut_r <= 1'b0;
			retry_cnt_r <= 32'h0;
		end else if (shut_trig_w) begin
			shut_r <= 1'b1;
			retry_cnt_r <= 32'h0;
		end else if (shut_r) begin
			shut_r <= !retry_done_w;
			retry_cnt_r <= retry_cnt_r + 32'h1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			scl_p_r <= 1'b1;
			sda_p_r <= 1'b1;
			fault_p_r <= 1'b0;
			ot_p_r <= 1'b0;
			nonrec_p_r <= 1'b0;
			outputs_on_r <= 1'b0;
			event_msg_r <= 1'b0;
		end else begin
			scl_p_r <= scl_s;
			sda_p_r <= sda_s;
			fault_p_r <= fault_in;
			ot_p_r <= overtemp_fault_in;
			nonrec_p_r <= nonrecov_fault_in;
			// Active-low requests: on needs turn-on low and hold-off high.
			outputs_on_r <= !eff_turn_n_w && eff_hold_n_w && !shut_r && !shut_trig_w;
			event_msg_r <= (fault_in && !fault_p_r) || (overtemp_fault_in && !ot_p_r)
				|| (nonrecov_fault_in && !nonrec_p_r);
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe_out = sda_oe_r;
	assign outputs_on_out = outputs_on_r;
	assign event_msg_out = event_msg_r;
	assign override_active_out = ctrl_r[ST_OVERRIDE_BIT];
endmodule : supply_status_override_ctrl

// ### verif/supply_status_override_ctrl_checker.sv
`timescale 1ns/1ns
module supply_status_checker(
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic fault_in,
	input wire logic overtemp_fault_in,
	input wire logic nonrecov_fault_in,
	input wire logic outputs_on_out,
	input wire logic event_msg_out,
	input wire logic override_active_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	sequence off_hold;
		!outputs_on_out [*8];
	endsequence
	sequence armed_ack;
		!scl_in ##[0:2] sda_oe_out;
	endsequence
	keep_on_a: assert property (override_active_out && nonrecov_fault_in && outputs_on_out
		|=> outputs_on_out) else $error("outputs dropped in override");
	shut_off_a: assert property (!override_active_out && nonrecov_fault_in
		|-> ##[1:2] !outputs_on_out) else $error("no shutdown on fault");
	retry_wait_a: assert property ($fell(nonrecov_fault_in) && !override_active_out
		|-> off_hold) else $error("retry too early");
	event_rise_a: assert property ($rose(fault_in || overtemp_fault_in || nonrecov_fault_in)
		|-> ##[1:2] event_msg_out) else $error("no event message");
	event_pulse_a: assert property (event_msg_out |=> !event_msg_out)
		else $error("event message too long");
	arm_on_ack_a: assert property ($rose(override_active_out) |-> armed_ack)
		else $error("override armed off the checksum ack");
	drive_scl_low_a: assert property ($changed(sda_oe_out) |-> !scl_in)
		else $error("data moved while clock high");
	ack_holds_a: assert property ($rose(sda_oe_out) |-> sda_oe_out [*4])
		else $error("drive too short");
	open_drain_a: assert property (sda_oe_out |-> !sda_out)
		else $error("data pin driven high");
endmodule : supply_status_checker
bind supply_status_override_ctrl supply_status_checker supply_status_checker_inst(
	.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .scl_in(scl_in), .sda_oe_out(sda_oe_out),
	.sda_out(sda_out), .fault_in(fault_in), .overtemp_fault_in(overtemp_fault_in),
	.nonrecov_fault_in(nonrecov_fault_in), .outputs_on_out(outputs_on_out),
	.event_msg_out(event_msg_out), .override_active_out(override_active_out));

// ### verif/ipmb_req.sv
`timescale 1ns/1ns
module ipmb_req(
	input wire logic clk_sys_in,
	input wire logic sda_oe_in,
	output logic scl_out,
	output logic sda_line_out
);
	logic sda_m = 1'b1;
	initial scl_out = 1'b1;
	// The wire has a pull-up, so a released line reads high.
	assign sda_line_out = sda_m & ~sda_oe_in;
	task automatic hc(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask : hc
	task automatic start();
		hc(4);
		sda_m = 1'b1;
		hc(12);
		scl_out = 1'b1;
		hc(12);
		sda_m = 1'b0;
		hc(12);
		scl_out = 1'b0;
	endtask : start
	task automatic stop();
		hc(4);
		sda_m = 1'b0;
		hc(12);
		scl_out = 1'b1;
		hc(12);
		sda_m = 1'b1;
		hc(12);
	endtask : stop
	// Data moves a few clocks after the fall, so no edge looks like a start or stop.
	task automatic xb(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			hc(4);
			sda_m = d[i];
			hc(12);
			scl_out = 1'b1;
			hc(12);
			q[i] = sda_line_out;
			scl_out = 1'b0;
		end
	endtask : xb
endmodule : ipmb_req

// ### verif/supply_status_override_ctrl_tb.sv
`timescale 1ns/1ns
module supply_status_override_ctrl_tb;
	import supply_status_pkg::*;
	logic clk_sys_in = 0, rstn_in = 0, turn_on_n_in = 0, hold_off_n_in = 1;
	logic fault_in = 0, overtemp_fault_in = 0, nonrecov_fault_in = 0;
	logic scl, sda, sda_oe_out, on_o, event_msg_out, ovr_o;
	logic [7:0] exp_q[$];
	logic [7:0] seen, d;
	logic [8:0] q;
	int mismatches = 0, total_checks = 0;
	event shown;
	always #2 clk_sys_in = ~clk_sys_in;
	supply_status_override_ctrl #(.RETRY_CYCLES(20)) supply_status_override_ctrl_inst(
		.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda), .sda_out(),
		.sda_oe_out(sda_oe_out), .turn_on_n_in(turn_on_n_in), .hold_off_n_in(hold_off_n_in),
		.fault_in(fault_in), .overtemp_fault_in(overtemp_fault_in),
		.nonrecov_fault_in(nonrecov_fault_in), .outputs_on_out(on_o),
		.event_msg_out(event_msg_out), .override_active_out(ovr_o));
	ipmb_req ipmb_req_inst(.clk_sys_in(clk_sys_in), .sda_oe_in(sda_oe_out), .scl_out(scl),
		.sda_line_out(sda));
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask : check
	always @(shown) check(seen, exp_q.pop_front());
	task automatic look(input logic [7:0] s, input logic [7:0] e);
		exp_q.push_back(e);
		seen = s;
		-> shown;
		#1;
	endtask : look
	task automatic complete_run();
		if (mismatches == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	function automatic logic [7:0] zs(input logic [7:0] x);
		return 8'h00 - STATUS_CMD - x;
	endfunction : zs
	task automatic wr(input logic [7:0] x, input logic bad);
		ipmb_req_inst.start();
		ipmb_req_inst.xb(9'h081, q);
		ipmb_req_inst.xb(9'h0ab, q);
		ipmb_req_inst.xb({x, 1'b1}, q);
		ipmb_req_inst.xb({zs(x) ^ {7'h00, bad}, 1'b1}, q);
		look({7'h00, q[0]}, 8'h00);
		ipmb_req_inst.stop();
		repeat (8) @(negedge clk_sys_in);
	endtask : wr
	task automatic rd(input logic [7:0] st);
		ipmb_req_inst.start();
		ipmb_req_inst.xb(9'h081, q);
		ipmb_req_inst.xb(9'h0ab, q);
		ipmb_req_inst.xb(9'h157, q);
		ipmb_req_inst.start();
		ipmb_req_inst.xb(9'h083, q);
		ipmb_req_inst.xb(9'h1fe, q);
		look(q[8:1], STATUS_CMD);
		ipmb_req_inst.xb(9'h1fe, q);
		look(q[8:1], st);
		ipmb_req_inst.xb(9'h1ff, q);
		look(q[8:1], zs(st));
		ipmb_req_inst.stop();
	endtask : rd
	task automatic refused(input logic [8:0] a, input logic [8:0] c);
		ipmb_req_inst.start();
		ipmb_req_inst.xb(a, q);
		ipmb_req_inst.xb(c, q);
		look({7'h00, q[0]}, 8'h01);
		ipmb_req_inst.stop();
	endtask : refused
	initial begin
		repeat (60000) @(posedge clk_sys_in);
		mismatches++;
		complete_run();
	end
	initial begin
		d = 8'($urandom(32'h0c912881));
		repeat (12) @(negedge clk_sys_in);
		rstn_in = 1;
		repeat (8) @(negedge clk_sys_in);
		look({7'h00, on_o}, 8'h01);
		rd(8'h02);
		refused(9'h085, 9'h0ab);
		refused(9'h081, 9'h0ad);
		// A corrupted third request must not count toward the three.
		wr(8'h80, 0);
		wr(8'h80, 0);
		wr(8'h80, 1);
		wr(8'h80, 0);
		wr(8'h80, 0);
		look({7'h00, ovr_o}, 8'h00);
		wr(8'h80, 0);
		look({7'h00, ovr_o}, 8'h01);
		rd(8'h82);
		nonrecov_fault_in = 1;
		repeat (30) @(negedge clk_sys_in);
		look({7'h00, on_o}, 8'h01);
		nonrecov_fault_in = 0;
		wr(8'h00, 0);
		look({7'h00, ovr_o}, 8'h00);
		nonrecov_fault_in = 1;
		repeat (10) @(negedge clk_sys_in);
		nonrecov_fault_in = 0;
		repeat (10) @(negedge clk_sys_in);
		look({7'h00, on_o}, 8'h00);
		repeat (30) @(negedge clk_sys_in);
		look({7'h00, on_o}, 8'h01);
		wr(8'h60, 0);
		overtemp_fault_in = 1;
		@(negedge clk_sys_in);
		overtemp_fault_in = 0;
		rd(8'h42);
		fault_in = 1;
		@(negedge clk_sys_in);
		fault_in = 0;
		rd(8'h02);
		turn_on_n_in = 1;
		wr(8'h10, 0);
		look({7'h00, on_o}, 8'h00);
		wr(8'h18, 0);
		look({7'h00, on_o}, 8'h01);
		wr(8'h1c, 0);
		look({7'h00, on_o}, 8'h00);
		repeat (2) begin
			d = 8'($urandom);
			wr(d, 0);
			rd({1'b0, d[6:2], 2'b11});
		end
		wr(8'h00, 0);
		turn_on_n_in = 0;
		hold_off_n_in = 0;
		repeat (8) @(negedge clk_sys_in);
		look({7'h00, on_o}, 8'h00);
		rd(8'h00);
		complete_run();
	end
endmodule : supply_status_override_ctrl_tb
